// ==== aam_map.vh ====
`ifndef AAM_MAP_VH
`define AAM_MAP_VH
// ----------------------------------------
// register offsets
// ----------------------------------------
`define AAM_REG_CAUSE      4'h0
`define AAM_REG_CLASS_LO   4'h1
`define AAM_REG_CLASS_HI   4'h2
`define AAM_REG_HORN_SEC   4'h3
`define AAM_REG_CMD        4'h4
`define AAM_REG_ACTIVE     4'h5
`define AAM_REG_UNACK      4'h6
`define AAM_REG_STATUS     4'h7
// ----------------------------------------
// anomaly classes
// ----------------------------------------
`define AAM_CLS_WARN       2'h0
`define AAM_CLS_UNLOAD     2'h1
`define AAM_CLS_DEACT      2'h2
`define AAM_CLS_ALARM      2'h3
// ----------------------------------------
// command codes and horn settings
// ----------------------------------------
`define AAM_CMD_SILENCE    8'h33
`define AAM_CMD_ACK        8'h34
`define AAM_CMD_RESET      8'h35
`define AAM_HORN_NEVER     10'h000
`define AAM_HORN_FOREVER   10'h3E7
`define AAM_HORN_RESET     10'h000
// ----------------------------------------
// timing
// ----------------------------------------
`define AAM_CLK_HZ         100000000
`define AAM_SEC_CYCLES     (`AAM_CLK_HZ / 1)
`endif

// ==== aam_sync.v ====
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// two-stage synchroniser for a bus of pins
// ----------------------------------------
module aam_sync #(
    parameter W = 2
) (
    input  wire         clk,
    input  wire         rstn,
    input  wire [W-1:0] d,
    output reg  [W-1:0] q
);
    reg [W-1:0] meta_q;

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            meta_q <= {W{1'b0}};
            q      <= {W{1'b0}};
        end else begin
            meta_q <= d;
            q      <= meta_q;
        end
    end
endmodule
`default_nettype wire

// ==== aam_anomaly_manager.v ====
// Overview of operation
// - warnings only signal; no engine stop, breaker stays closed
// - unload: ramp load down fast, then open breaker, cool-down stop
// - deactivation: open breaker at once, then cool-down stop
// - alarm: open breaker at once, emergency stop without cool-down
// - unload, deactivation, alarm stay latched and block restart until reset
// - new anomaly turns on hooter and every external horn output
// - each active anomaly has unacknowledged flag, set on activation, drives blink
// - horn duration zero: hooters never turn on
// - horn duration 999: hooters stay on until silence command
// - other durations: hooters off that many seconds after last activation
// - command 51 silences both hooters
// - command 52 acknowledges all active anomalies
// - command 53 resets acknowledged anomalies whose causes are gone
// - acknowledge input acts once on its rising edge only
// - reset input acts once on its rising edge only
// - acknowledged warning clears itself once cause disappears
// - reset clears only anomalies whose cause is inactive
//
// Chosen here: the address-and-strobe port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "aam_map.vh"
module aam_anomaly_manager #(
    parameter N          = 16,
    parameter HORN_OUTS  = 2,
    parameter SEC_CYCLES = `AAM_SEC_CYCLES
) (
    input  wire                 clk,
    input  wire                 rstn,
    input  wire [N-1:0]         cause,
    input  wire                 ack_pin,
    input  wire                 reset_pin,
    input  wire                 unload_done,
    input  wire [3:0]           addr,
    input  wire [15:0]          wdata,
    input  wire                 wr,
    input  wire                 rd,
    output reg  [15:0]          rdata,
    output reg                  hooter,
    output reg  [HORN_OUTS-1:0] external_horn_output_function,
    output reg                  any_warning,
    output reg                  unload_ramp_req,
    output reg                  generator_breaker_open,
    output reg                  engine_stop_cooldown,
    output reg                  engine_stop_emergency,
    output reg                  restart_block,
    output reg                  blink
);
    // ----------------------------------------
    // helpers
    // ----------------------------------------
    function [N-1:0] class_mask;
        input [2*N-1:0] cls;
        input [1:0]     want;
        integer         i;
        begin
            class_mask = {N{1'b0}};
            for (i = 0; i < N; i = i + 1)
                class_mask[i] = (cls[2*i +: 2] == want);
        end
    endfunction

    // ----------------------------------------
    // pin inputs and cause inputs
    // ----------------------------------------
    wire [N+2:0] pins_s;
    reg  [1:0]   pin_prev_q;

    // unload_done comes from the load controller's pin, so it is synced too
    aam_sync #(.W(N+3)) u_sync (
        .clk  (clk),
        .rstn (rstn),
        .d    ({unload_done, reset_pin, ack_pin, cause}),
        .q    (pins_s)
    );

    wire [N-1:0] cause_s = pins_s[N-1:0];
    wire unload_s   = pins_s[N+2];
    wire ack_edge   = pins_s[N]   & ~pin_prev_q[0];
    wire reset_edge = pins_s[N+1] & ~pin_prev_q[1];

    // ----------------------------------------
    // registers
    // ----------------------------------------
    reg [2*N-1:0] class_q;
    reg [9:0]     horn_sec_q;
    reg [N-1:0]   active_q;
    reg [N-1:0]   unack_q;
    reg [N-1:0]   cause_prev_q;
    reg [9:0]     sec_left_q;
    reg [31:0]    cyc_q;
    reg           horn_on_q;

    wire cmd_wr   = wr && (addr == `AAM_REG_CMD);
    wire cmd_sil  = cmd_wr && (wdata[7:0] == `AAM_CMD_SILENCE);
    wire cmd_ack  = (cmd_wr && (wdata[7:0] == `AAM_CMD_ACK)) || ack_edge;
    wire cmd_rst  = (cmd_wr && (wdata[7:0] == `AAM_CMD_RESET)) || reset_edge;

    wire [N-1:0] rise    = cause_s & ~cause_prev_q;
    wire [N-1:0] new_act = rise & ~active_q;
    wire         any_new = |new_act;
    wire [N-1:0] warn_m  = class_mask(class_q, `AAM_CLS_WARN);

    // ----------------------------------------
    // anomaly state
    // ----------------------------------------
    reg [N-1:0] active_d;
    reg [N-1:0] unack_d;

    always @* begin
        active_d = active_q;
        unack_d  = unack_q;
        if (cmd_ack)
            unack_d = {N{1'b0}};
        // acknowledged warnings go once their cause is gone
        active_d = active_d & ~(warn_m & ~unack_d & ~cause_s);
        // reset leaves anything whose cause persists
        if (cmd_rst)
            active_d = active_d & ~(~cause_s & ~unack_d);
        // activation wins over any clear in the same cycle
        active_d = active_d | new_act;
        unack_d  = (unack_d | new_act) & active_d;
    end

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            pin_prev_q   <= 2'h0;
            cause_prev_q <= {N{1'b0}};
            active_q     <= {N{1'b0}};
            unack_q      <= {N{1'b0}};
        end else begin
            pin_prev_q   <= pins_s[N+1:N];
            cause_prev_q <= cause_s;
            active_q     <= active_d;
            unack_q      <= unack_d;
        end
    end

    // ----------------------------------------
    // configuration writes
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            class_q    <= {2*N{1'b0}};
            horn_sec_q <= `AAM_HORN_RESET;
        end else if (wr) begin
            if (addr == `AAM_REG_CLASS_LO)
                class_q[15:0] <= wdata;
            if (addr == `AAM_REG_CLASS_HI)
                class_q[31:16] <= wdata;
            if (addr == `AAM_REG_HORN_SEC)
                horn_sec_q <= wdata[9:0];
        end
    end

    // ----------------------------------------
    // horn timing
    // ----------------------------------------
    // one second tick only runs while the horn sounds
    wire sec_tick = horn_on_q && (cyc_q == SEC_CYCLES - 1);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            horn_on_q  <= 1'b0;
            sec_left_q <= 10'h000;
            cyc_q      <= 32'h0000_0000;
        end else if (any_new && horn_sec_q != `AAM_HORN_NEVER) begin
            horn_on_q  <= 1'b1;
            sec_left_q <= horn_sec_q;
            cyc_q      <= 32'h0000_0000;
        end else if (cmd_sil || horn_sec_q == `AAM_HORN_NEVER) begin
            horn_on_q  <= 1'b0;
        end else if (horn_on_q) begin
            cyc_q <= sec_tick ? 32'h0000_0000 : cyc_q + 32'h0000_0001;
            if (sec_tick && horn_sec_q != `AAM_HORN_FOREVER) begin
                sec_left_q <= sec_left_q - 10'h001;
                if (sec_left_q <= 10'h001)
                    horn_on_q <= 1'b0;
            end
        end
    end

    // ----------------------------------------
    // actions per class
    // ----------------------------------------
    wire [N-1:0] unl_a = active_q & class_mask(class_q, `AAM_CLS_UNLOAD);
    wire [N-1:0] dea_a = active_q & class_mask(class_q, `AAM_CLS_DEACT);
    wire [N-1:0] alm_a = active_q & class_mask(class_q, `AAM_CLS_ALARM);

    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            hooter                        <= 1'b0;
            external_horn_output_function <= {HORN_OUTS{1'b0}};
            any_warning                   <= 1'b0;
            unload_ramp_req               <= 1'b0;
            generator_breaker_open        <= 1'b0;
            engine_stop_cooldown          <= 1'b0;
            engine_stop_emergency         <= 1'b0;
            restart_block                 <= 1'b0;
            blink                         <= 1'b0;
        end else begin
            hooter                        <= horn_on_q;
            external_horn_output_function <= {HORN_OUTS{horn_on_q}};
            any_warning                   <= |(active_q & warn_m);
            // unload ramps first; breaker waits for the ramp end
            unload_ramp_req        <= |unl_a && !unload_s;
            generator_breaker_open <= (|unl_a && unload_s) | |dea_a | |alm_a;
            engine_stop_cooldown   <= ((|unl_a && unload_s) | |dea_a) && !(|alm_a);
            engine_stop_emergency  <= |alm_a;
            restart_block          <= |(unl_a | dea_a | alm_a);
            blink                  <= |unack_q;
        end
    end

    // ----------------------------------------
    // register reads
    // ----------------------------------------
    always @(posedge clk or negedge rstn) begin
        if (!rstn) begin
            rdata <= 16'h0000;
        end else if (rd) begin
            case (addr)
                `AAM_REG_CAUSE:    rdata <= cause_s;
                `AAM_REG_CLASS_LO: rdata <= class_q[15:0];
                `AAM_REG_CLASS_HI: rdata <= class_q[31:16];
                `AAM_REG_HORN_SEC: rdata <= {6'h00, horn_sec_q};
                `AAM_REG_ACTIVE:   rdata <= active_q;
                `AAM_REG_UNACK:    rdata <= unack_q;
                `AAM_REG_STATUS:   rdata <= {15'h0000, horn_on_q};
                default:           rdata <= 16'h0000;
            endcase
        end else begin
            rdata <= 16'h0000;
        end
    end
endmodule
`default_nettype wire

// ==== aam_panel.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aam_map.vh"
module aam_panel (
    input  wire logic        clk,
    input  wire logic        hooter,
    input  wire logic [15:0] rdata,
    output var  logic [3:0]  addr = 4'h0,
    output var  logic [15:0] wdata = 16'h0000,
    output var  logic        wr = 1'b0,
    output var  logic        rd = 1'b0
);
    // --------
    // bus cycles
    // --------
    task automatic put(input logic [3:0] a, input logic [15:0] d);
        @(posedge clk);
        addr  <= a;
        wdata <= d;
        wr    <= 1'b1;
        @(posedge clk);
        wr    <= 1'b0;
        // stale data must not look valid
        wdata <= ~d;
    endtask
    task automatic get(input logic [3:0] a, output logic [15:0] d);
        @(posedge clk);
        addr <= a;
        rd   <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        d = rdata;
    endtask
    // single button, meaning depends on horn state
    task automatic button;
        put(`AAM_REG_CMD, {8'h00, hooter ? `AAM_CMD_SILENCE : `AAM_CMD_ACK});
    endtask
endmodule
`default_nettype wire

// ==== aam_checker_assertions.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aam_map.vh"
module aam_checker #(
    parameter HORN_OUTS = 2
) (
    input wire logic                 clk,
    input wire logic                 rstn,
    input wire logic [3:0]           addr,
    input wire logic [15:0]          wdata,
    input wire logic                 wr,
    input wire logic                 hooter,
    input wire logic [HORN_OUTS-1:0] external_horn_output_function,
    input wire logic                 blink,
    input wire logic                 restart_block,
    input wire logic                 generator_breaker_open,
    input wire logic                 engine_stop_cooldown,
    input wire logic                 engine_stop_emergency
);
    logic [9:0] horn_q;
    logic       sil;
    logic       ackc;
    assign sil  = wr && addr == `AAM_REG_CMD && wdata == {8'h00, `AAM_CMD_SILENCE};
    assign ackc = wr && addr == `AAM_REG_CMD && wdata == {8'h00, `AAM_CMD_ACK};
    always_ff @(posedge clk or negedge rstn) begin
        if (!rstn)
            horn_q <= 10'h000;
        else if (wr && addr == `AAM_REG_HORN_SEC)
            horn_q <= wdata[9:0];
    end
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!rstn);
    chk_horn_mirror: assert property (external_horn_output_function == {HORN_OUTS{hooter}})
        else $error("horn outputs differ from hooter");
    chk_horn_never: assert property ($rose(hooter) |-> $past(horn_q) != 10'h000)
        else $error("hooter on with duration zero");
    chk_silence_off: assert property (sil |-> ##[1:3] !hooter)
        else $error("hooter still on after silence");
    chk_silence_keep: assert property (sil |-> ##1 $stable(blink) [*3])
        else $error("silence changed anomaly state");
    chk_ack_blink: assert property (ackc |-> ##[1:3] !blink)
        else $error("blink kept after acknowledge");
    chk_new_unack: assert property ($rose(hooter) |-> ##[0:1] blink)
        else $error("new anomaly not flagged");
    chk_open_latch: assert property ($rose(generator_breaker_open) |-> ##[0:2] restart_block)
        else $error("breaker open without restart block");
    chk_alarm_open: assert property ($rose(engine_stop_emergency) |-> ##[0:1] generator_breaker_open)
        else $error("emergency stop with breaker closed");
    chk_alarm_nocool: assert property (engine_stop_emergency |-> !engine_stop_cooldown)
        else $error("emergency stop with cool-down");
endmodule
bind aam_anomaly_manager aam_checker #(.HORN_OUTS(HORN_OUTS)) aam_checker_inst (
    .clk(clk), .rstn(rstn), .addr(addr), .wdata(wdata), .wr(wr), .hooter(hooter),
    .external_horn_output_function(external_horn_output_function), .blink(blink),
    .restart_block(restart_block), .generator_breaker_open(generator_breaker_open),
    .engine_stop_cooldown(engine_stop_cooldown), .engine_stop_emergency(engine_stop_emergency));
`default_nettype wire

// ==== tb.sv ====
`timescale 1ns/1ps
`default_nettype none
`include "aam_map.vh"
module tb;
    typedef struct packed {logic [1:0] cls; logic done; logic [5:0] exp;} aam_row_t;
    logic        clk = 1'b0;
    logic        rstn = 1'b0;
    logic [15:0] cause = 16'h0000;
    logic        ack_pin = 1'b0;
    logic        reset_pin = 1'b0;
    logic        unload_done = 1'b0;
    logic [3:0]  addr;
    logic [15:0] wdata, rdata, v;
    logic        wr, rd, hooter, blink, warn, ramp, brk, cool, emer, blk;
    logic [1:0]  horn;
    int          n_errors = 0;
    int          cmp_count = 0;
    int          n;
    aam_row_t    rows [5] = '{'{2'h0, 1'b0, 6'h20}, '{2'h1, 1'b0, 6'h11},
        '{2'h1, 1'b1, 6'h0D}, '{2'h2, 1'b0, 6'h0D}, '{2'h3, 1'b0, 6'h0B}};
    always #5 clk = ~clk;
    // short second keeps horn timeouts brief
    aam_anomaly_manager #(.SEC_CYCLES(10)) aam_anomaly_manager_inst (
        .clk(clk), .rstn(rstn), .cause(cause), .ack_pin(ack_pin), .reset_pin(reset_pin),
        .unload_done(unload_done), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
        .rdata(rdata), .hooter(hooter), .external_horn_output_function(horn),
        .any_warning(warn), .unload_ramp_req(ramp), .generator_breaker_open(brk),
        .engine_stop_cooldown(cool), .engine_stop_emergency(emer), .restart_block(blk),
        .blink(blink));
    aam_panel aam_panel_inst (.clk(clk), .hooter(hooter), .rdata(rdata), .addr(addr),
        .wdata(wdata), .wr(wr), .rd(rd));
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value at %0t: saw %h expected %h", $time, seen, exp);
        end
    endtask
    task automatic complete_run;
        $display("compares %0d mismatches %0d", cmp_count, n_errors);
        if (n_errors == 0 && cmp_count > 0)
            $display("Testbench passed");
        else
            $display("Testbench failed");
        $finish;
    endtask
    task automatic wt(input int c);
        repeat (c) @(posedge clk);
        #1;
    endtask
    task automatic cmd(input logic [7:0] c);
        aam_panel_inst.put(`AAM_REG_CMD, {8'h00, c});
        wt(3);
    endtask
    initial begin
        wt(20);
        rstn <= 1'b1;
        wt(2);
        aam_panel_inst.put(`AAM_REG_HORN_SEC, 16'h03E7);
        foreach (rows[i]) begin
            aam_panel_inst.put(`AAM_REG_CLASS_LO, {14'h0000, rows[i].cls});
            unload_done <= rows[i].done;
            cause[0] <= 1'b1;
            wt(8);
            chk({warn, ramp, brk, cool, emer, blk}, rows[i].exp);
            chk({hooter, horn, blink}, 4'hF);
            cmd(`AAM_CMD_SILENCE);
            chk({hooter, blink, blk}, {2'b01, rows[i].exp[0]});
            cmd(`AAM_CMD_ACK);
            chk(blink, 1'b0);
            cmd(`AAM_CMD_RESET);
            chk(blk, rows[i].exp[0]);
            cause[0] <= 1'b0;
            unload_done <= 1'b0;
            wt(5);
            cmd(`AAM_CMD_RESET);
            chk({warn, ramp, brk, cool, emer, blk, hooter}, 7'h00);
            $display("class row %0d done", i);
        end
        aam_panel_inst.put(`AAM_REG_HORN_SEC, 16'h0000);
        aam_panel_inst.put(`AAM_REG_CLASS_LO, 16'h00C0);
        cause[1] <= 1'b1;
        wt(8);
        chk({hooter, blink}, 2'b01);
        ack_pin <= 1'b1;
        wt(6);
        chk(blink, 1'b0);
        cause[2] <= 1'b1;
        wt(8);
        chk(blink, 1'b1);
        ack_pin <= 1'b0;
        aam_panel_inst.button();
        wt(3);
        chk(blink, 1'b0);
        cause[3] <= 1'b1;
        wt(8);
        cmd(`AAM_CMD_ACK);
        reset_pin <= 1'b1;
        wt(6);
        chk({blk, emer}, 2'b11);
        cause[3] <= 1'b0;
        wt(8);
        chk(blk, 1'b1);
        reset_pin <= 1'b0;
        wt(4);
        reset_pin <= 1'b1;
        wt(6);
        chk(blk, 1'b0);
        $display("input edge test done");
        aam_panel_inst.put(`AAM_REG_HORN_SEC, 16'h0002);
        cause[4] <= 1'b1;
        wt(8);
        aam_panel_inst.button();
        wt(3);
        chk({hooter, blink}, 2'b01);
        cause[5] <= 1'b1;
        wt(6);
        chk(hooter, 1'b1);
        n = 6;
        while (hooter === 1'b1 && n < 100) begin
            wt(1);
            n++;
        end
        if (n >= 100) begin
            n_errors++;
            complete_run();
        end
        chk(n >= 22 && n <= 26, 1'b1);
        aam_panel_inst.get(`AAM_REG_HORN_SEC, v);
        chk(v, 16'h0002);
        aam_panel_inst.get(4'hF, v);
        chk(v, 16'h0000);
        $display("horn timeout test done");
        rstn <= 1'b0;
        wt(2);
        chk({warn, ramp, brk, cool, emer, blk, hooter, blink}, 8'h00);
        rstn <= 1'b1;
        wt(2);
        chk({warn, blk, hooter, blink}, 4'h0);
        wt(8);
        chk({warn, hooter}, 2'b10);
        $display("mid-run reset test done");
        complete_run();
    end
endmodule
`default_nettype wire
